// ===== ppi_host_pkg.sv
// constants, pin carrier and state types for the parallel port host controller
package ppi_host_pkg;

    // clock and device bus timing, figures in ns
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned ADDR_SETUP_NS  = 60;   // select/address before strobe
    localparam int unsigned STROBE_NS      = 300;  // read or write strobe width
    localparam int unsigned DATA_HOLD_NS   = 40;   // address/data after strobe
    localparam int unsigned RECOVERY_NS    = 300;  // gap before next access

    // least time in whole cycles, never below one
    function automatic int unsigned ceilCycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceilCycles

    localparam logic [4:0] SETUP_CYC    = 5'(ceilCycles(ADDR_SETUP_NS));
    localparam logic [4:0] STROBE_CYC   = 5'(ceilCycles(STROBE_NS));
    localparam logic [4:0] HOLD_CYC     = 5'(ceilCycles(DATA_HOLD_NS));
    localparam logic [4:0] RECOVERY_CYC = 5'(ceilCycles(RECOVERY_NS));

    // controller register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_COMMAND  = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_READDATA = 8'h08;
    localparam logic [7:0] OFF_DEVRESET = 8'h0C;
    localparam logic [7:0] OFF_CONFIG   = 8'h10;
    localparam logic [7:0] OFF_BITOP    = 8'h14;

    // field positions
    localparam int unsigned CMD_SEL_LSB   = 8;   // command [9:8] port select
    localparam int unsigned CMD_READ_BIT  = 12;  // command [12] 1 = read
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_DONE_BIT   = 1;
    localparam int unsigned ST_REFUSE_BIT = 2;
    localparam int unsigned BITOP_SET_BIT = 3;   // bitop [2:0] bit, [3] set

    // device port select codes
    localparam logic [1:0] SEL_PORT_A  = 2'h0;
    localparam logic [1:0] SEL_PORT_B  = 2'h1;
    localparam logic [1:0] SEL_PORT_C  = 2'h2;
    localparam logic [1:0] SEL_CONTROL = 2'h3;

    // device control word facts
    localparam logic [7:0] CONFIG_RESET     = 8'h9B;
    localparam int unsigned CONTROL_FLAG_BIT = 7;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // device bus access phases
    typedef enum logic [2:0] {
        PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD, PH_RECOVER
    } busPhase_t;

    // everything driven toward the device pins
    typedef struct packed {
        logic       selectN;      // device select, active low
        logic       readN;        // read strobe, active low
        logic       writeN;       // write strobe, active low
        logic [1:0] portSelect;   // port_select_bit1, port_select_bit0
        logic [7:0] dataOut;      // host_data_bus value when driven
        logic       dataOe;       // high while the host drives the data bus
        logic       devReset;     // device reset, active high
    } devPins_t;

endpackage : ppi_host_pkg

// ===== ppi_host.sv
// host controller that drives a parallel port device from an axi4-lite slave
`timescale 1ns/1ps
// What this block does
// RL1: device reset loads config 9Bh, ports input
// RL2: select low enables strobes; else bus released
// RL3: read with select drives chosen item
// RL4: write with select loads chosen target
// RL5: select lines choose exactly one target
// RL6: data bus three-state, driven on reads
// RL7: control register is writable and readable
// RL8: control word reads back with D7 set
// RL9: group A: port A, upper C
// RL10: port A latches its input separately
// RL11: port B has latch and input buffer
// RL12: port C input unlatched, reads pins
// RL13: port C splits into two halves
// RL14: select lines come from address LSBs; here they come from command bits [9:8]
// RL15: control write clears output ports to zero
// RL16: mode change resets outputs and flags
// RL17: single write sets or clears port C bit
// RL18: host never asserts both strobes together
// RL19: D7 low write is bit op only
module ppi_host
    import ppi_host_pkg::*;
(
    input  wire logic        clk_sys,    // 50 MHz system clock
    input  wire logic        rst,        // synchronous, active high
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // device side
    output devPins_t         devPins,    // strobes, select, data, reset
    input  wire logic [7:0]  hostDataIn  // level of host_data_bus
);

    // whole state of the controller in one word
    typedef struct packed {
        busPhase_t   phase;      // device access phase
        logic [4:0]  count;      // cycles left in the phase after this one
        logic        isRead;     // current access is a read
        devPins_t    pins;       // registered device pins
        logic [7:0]  readData;   // last byte read from the device
        logic [7:0]  shadow;     // shadow of the last mode word
        logic        done;       // sticky: access finished
        logic        refused;    // sticky: command dropped
        logic        resetLevel; // software reset request
        logic        awready;
        logic        wready;
        logic        awTaken;    // write address held
        logic        wTaken;     // write data held
        logic [7:0]  awaddrHeld;
        logic [31:0] wdataHeld;
        logic [3:0]  wstrbHeld;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ctrlState_t;

    ctrlState_t state;       // registered state
    ctrlState_t next_state;  // combinational next value

    // keep the old bytes where the strobe is low
    function automatic logic [31:0] byteMerge(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0]  strb
    );
        logic [31:0] merged;
        merged = oldWord;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                merged[i*8 +: 8] = newWord[i*8 +: 8];
            end
        end
        return merged;
    endfunction : byteMerge

    // next-state logic: bus slave, command launch and device access
    always_comb
    begin
        logic [31:0] wordIn;     // write data after byte merge
        logic        launch;     // start a device access this cycle
        logic [1:0]  launchSel;  // target of that access
        logic [7:0]  launchData; // byte to send
        logic        launchRead; // access direction
        logic        setDone;    // access completes this cycle
        logic        setRefuse;  // a command was dropped this cycle
        logic        clrDone;
        logic        clrRefuse;
        wordIn     = 32'h0000_0000;
        launch     = 1'b0;
        launchSel  = SEL_PORT_A;
        launchData = 8'h00;
        launchRead = 1'b0;
        setDone    = 1'b0;
        setRefuse  = 1'b0;
        clrDone    = 1'b0;
        clrRefuse  = 1'b0;
        next_state = state;

        // address and data are taken in either order
        if (awvalid && state.awready)
        begin
            next_state.awTaken    = 1'b1;
            next_state.awaddrHeld = awaddr;
            next_state.awready    = 1'b0;
        end
        if (wvalid && state.wready)
        begin
            next_state.wTaken    = 1'b1;
            next_state.wdataHeld = wdata;
            next_state.wstrbHeld = wstrb;
            next_state.wready    = 1'b0;
        end

        // both halves held: apply the write and answer
        if (state.awTaken && state.wTaken && !state.bvalid)
        begin
            next_state.awTaken = 1'b0;
            next_state.wTaken  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = RESP_OKAY;
            wordIn = byteMerge(32'h0000_0000, state.wdataHeld,
                               state.wstrbHeld);
            if (state.awaddrHeld == OFF_COMMAND)
            begin
                // select lines come from command bits [9:8], not the address LSBs (see RL14)
                launch     = 1'b1;
                launchData = wordIn[7:0];
                launchSel  = wordIn[CMD_SEL_LSB +: 2];
                launchRead = wordIn[CMD_READ_BIT];
            end
            else if (state.awaddrHeld == OFF_STATUS)
            begin
                // write one to clear the sticky flags
                clrDone   = wordIn[ST_DONE_BIT];
                clrRefuse = wordIn[ST_REFUSE_BIT];
            end
            else if (state.awaddrHeld == OFF_DEVRESET)
            begin
                if (state.wstrbHeld[0])
                begin
                    next_state.resetLevel = wordIn[0];
                end
            end
            else if (state.awaddrHeld == OFF_BITOP)
            begin
                // single port C bit, D7 low marks it (see RL17)
                launch     = 1'b1;
                launchSel  = SEL_CONTROL;
                launchData = {4'h0, wordIn[2:0], wordIn[BITOP_SET_BIT]};
                launchRead = 1'b0;
            end
            else if (state.awaddrHeld != OFF_READDATA &&
                     state.awaddrHeld != OFF_CONFIG)
            begin
                next_state.bresp = RESP_SLVERR;  // unmapped
            end
        end

        // write response handshake reopens both channels
        if (state.bvalid && bready)
        begin
            next_state.bvalid  = 1'b0;
            next_state.awready = 1'b1;
            next_state.wready  = 1'b1;
        end

        // read channel: one read at a time, answer next cycle
        if (arvalid && state.arready)
        begin
            next_state.arready = 1'b0;
            next_state.rvalid  = 1'b1;
            next_state.rresp   = RESP_OKAY;
            next_state.rdata   = 32'h0000_0000;
            if (araddr == OFF_STATUS)
            begin
                next_state.rdata[ST_BUSY_BIT]   = (state.phase != PH_IDLE);
                next_state.rdata[ST_DONE_BIT]   = state.done;
                next_state.rdata[ST_REFUSE_BIT] = state.refused;
            end
            else if (araddr == OFF_READDATA)
            begin
                next_state.rdata[7:0] = state.readData;
            end
            else if (araddr == OFF_DEVRESET)
            begin
                next_state.rdata[0] = state.resetLevel;
            end
            else if (araddr == OFF_CONFIG)
            begin
                next_state.rdata[7:0] = state.shadow;
            end
            else if (araddr != OFF_COMMAND && araddr != OFF_BITOP)
            begin
                next_state.rresp = RESP_SLVERR;  // unmapped
            end
        end
        if (state.rvalid && rready)
        begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end

        // device reset pin follows the request (see RL1)
        next_state.pins.devReset = state.resetLevel;
        if (state.resetLevel)
        begin
            // device reloads its control word; mirror it (see RL1)
            next_state.shadow = CONFIG_RESET;
        end

        // device access sequencer
        case (state.phase)
            PH_IDLE:
            begin
                // busy or device in reset: command is dropped
                if (launch && state.resetLevel)
                begin
                    setRefuse = 1'b1;
                end
                else if (launch)
                begin
                    // one select code per access (see RL5)
                    next_state.phase           = PH_SETUP;
                    next_state.count           = SETUP_CYC - 5'd1;
                    next_state.isRead          = launchRead;
                    next_state.pins.selectN    = 1'b0;      // see RL2
                    next_state.pins.portSelect = launchSel;
                    next_state.pins.dataOut    = launchData;
                    // drive only on writes; reads leave it (see RL6)
                    next_state.pins.dataOe     = !launchRead;
                end
            end
            PH_SETUP:
            begin
                if (launch)
                begin
                    setRefuse = 1'b1;
                end
                if (state.count == 5'd0)
                begin
                    // exactly one strobe low at a time (see RL18)
                    next_state.phase       = PH_STROBE;
                    next_state.count       = STROBE_CYC - 5'd1;
                    next_state.pins.readN  = !state.isRead;  // see RL3
                    next_state.pins.writeN = state.isRead;   // see RL4
                end
                else
                begin
                    next_state.count = state.count - 5'd1;
                end
            end
            PH_STROBE:
            begin
                if (launch)
                begin
                    setRefuse = 1'b1;
                end
                if (state.count == 5'd0)
                begin
                    // sample at the last low cycle of the read strobe
                    if (state.isRead)
                    begin
                        next_state.readData = hostDataIn;  // see RL3
                    end
                    next_state.phase       = PH_HOLD;
                    next_state.count       = HOLD_CYC - 5'd1;
                    next_state.pins.readN  = 1'b1;
                    next_state.pins.writeN = 1'b1;
                end
                else
                begin
                    next_state.count = state.count - 5'd1;
                end
            end
            PH_HOLD:
            begin
                if (launch)
                begin
                    setRefuse = 1'b1;
                end
                if (state.count == 5'd0)
                begin
                    // release select and bus together (see RL2)
                    next_state.phase        = PH_RECOVER;
                    next_state.count        = RECOVERY_CYC - 5'd1;
                    next_state.pins.selectN = 1'b1;
                    next_state.pins.dataOe  = 1'b0;
                    // only a mode word updates the shadow (see RL19)
                    if (!state.isRead &&
                        state.pins.portSelect == SEL_CONTROL &&
                        state.pins.dataOut[CONTROL_FLAG_BIT])
                    begin
                        next_state.shadow = state.pins.dataOut;  // see RL7
                    end
                end
                else
                begin
                    next_state.count = state.count - 5'd1;
                end
            end
            PH_RECOVER:
            begin
                if (launch)
                begin
                    setRefuse = 1'b1;
                end
                if (state.count == 5'd0)
                begin
                    next_state.phase = PH_IDLE;
                    setDone          = 1'b1;
                end
                else
                begin
                    next_state.count = state.count - 5'd1;
                end
            end
            default:
            begin
                next_state.phase = PH_IDLE;
            end
        endcase

        // sticky flags: a set in the clearing cycle wins
        next_state.done    = setDone   | (state.done    & ~clrDone);
        next_state.refused = setRefuse | (state.refused & ~clrRefuse);
    end

    // state register; reset holds the device in reset as well
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state            <= '0;
            state.phase      <= PH_IDLE;
            state.pins       <= '{selectN: 1'b1, readN: 1'b1,
                                  writeN: 1'b1, portSelect: 2'h0,
                                  dataOut: 8'h00, dataOe: 1'b0,
                                  devReset: 1'b1};
            state.shadow     <= CONFIG_RESET;
            state.resetLevel <= 1'b1;
            state.awready    <= 1'b1;
            state.wready     <= 1'b1;
            state.arready    <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    // every output straight from the state register
    assign awready = state.awready;
    assign wready  = state.wready;
    assign bvalid  = state.bvalid;
    assign bresp   = state.bresp;
    assign arready = state.arready;
    assign rvalid  = state.rvalid;
    assign rdata   = state.rdata;
    assign rresp   = state.rresp;
    assign devPins = state.pins;

endmodule : ppi_host

// ===== ppi_host_monitor.sv
// concurrent checks on the device pins and bus replies of the host
`timescale 1ns/1ps
module ppi_host_monitor
    import ppi_host_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       awvalid,
    input wire logic       awready,
    input wire logic       wvalid,
    input wire logic       wready,
    input wire logic       arvalid,
    input wire logic       arready,
    input wire logic       rvalid,
    input wire logic       bvalid,
    input wire devPins_t   devPins
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       strobeLow;  // either strobe asserted
    logic [4:0] strobeLen;  // low cycles of the current strobe
    assign strobeLow = !devPins.readN || !devPins.writeN;
    // width is judged when the strobe ends, so count while it lasts
    always_ff @(posedge clk_sys)
        strobeLen <= (rst || !strobeLow) ? 5'h00 : strobeLen + 5'h01;
    // select settled, no strobe yet
    sequence setupPhase;
        (!devPins.selectN && !strobeLow) [*3];
    endsequence
    // select kept after the strobe, then dropped
    sequence holdPhase;
        !devPins.selectN [*2] ##1 devPins.selectN;
    endsequence
    AST_ONE_STROBE: assert property (devPins.readN || devPins.writeN)
        else $error("both strobes low");
    AST_STROBE_SELECTED: assert property (strobeLow |-> !devPins.selectN)
        else $error("strobe without select");
    AST_NO_DRIVE_IN_READ: assert property (!devPins.readN |-> !devPins.dataOe)
        else $error("host drives bus during read");
    AST_WRITE_DRIVES: assert property (!devPins.writeN |-> devPins.dataOe)
        else $error("write strobe without data");
    AST_SETUP: assert property ($fell(devPins.selectN) |-> setupPhase ##1 strobeLow)
        else $error("setup before strobe wrong");
    AST_STROBE_WIDTH: assert property (!strobeLow && $past(strobeLow) |-> strobeLen == 5'h0F)
        else $error("strobe width wrong");
    AST_HOLD: assert property ($fell(strobeLow) |-> holdPhase)
        else $error("hold after strobe wrong");
    AST_TARGET_STABLE: assert property (!devPins.selectN && !$past(devPins.selectN)
        |-> $stable({devPins.portSelect, devPins.dataOut}))
        else $error("target changed while selected");
    AST_QUIET_IN_RESET: assert property (devPins.devReset |-> devPins.selectN)
        else $error("access while device in reset");
    AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write response late");
    AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response late");
endmodule : ppi_host_monitor

// ===== ppi_device_model.sv
// behavioural model of the parallel port device at the far side
`timescale 1ns/1ps
module ppi_device_model
    import ppi_host_pkg::*;
(
    input  wire logic     clk_sys,    // only paces the released bus
    input  wire devPins_t devPins,    // pins from the controller
    output logic [7:0]    hostDataIn  // resolved data bus level
);
    logic [7:0] portA, portB, portC;  // output latches, ones after device reset
    logic [7:0] control;              // stored mode word
    logic [7:0] lastBus;              // last bus level
    logic [7:0] devData;              // byte offered on reads
    logic       devOe;                // device drives the bus
    // writes land at the end of the strobe, as on the real part
    always @(posedge devPins.writeN or posedge devPins.devReset)
        if (devPins.devReset)
        begin
            control = CONFIG_RESET;
            {portA, portB, portC} = 24'hFFFFFF;  // bus hold ones
        end
        else if (!devPins.selectN)
            case (devPins.portSelect)
                SEL_PORT_A: portA = devPins.dataOut;
                SEL_PORT_B: portB = devPins.dataOut;
                SEL_PORT_C: portC = devPins.dataOut;
                default:
                    if (devPins.dataOut[7])   // mode word
                    begin
                        control = devPins.dataOut;
                        // outputs restart from zero
                        if (!control[4]) portA = 8'h00;
                        if (!control[1]) portB = 8'h00;
                        if (!control[3]) portC[7:4] = 4'h0;
                        if (!control[0]) portC[3:0] = 4'h0;
                    end
                    else                      // single bit op
                        portC[devPins.dataOut[3:1]] = devPins.dataOut[0];
            endcase
    // only an enabled read drives the bus
    assign devOe = !devPins.selectN && !devPins.readN && !devPins.devReset;
    assign devData = (devPins.portSelect == SEL_PORT_A) ? portA :
                     (devPins.portSelect == SEL_PORT_B) ? portB :
                     (devPins.portSelect == SEL_PORT_C) ? portC :
                     (control | 8'h80);
    // a released bus keeps no value: show a changing pattern
    assign hostDataIn = devPins.dataOe ? devPins.dataOut :
                        devOe ? devData : ~lastBus;
    always @(posedge clk_sys)
        lastBus <= hostDataIn;
endmodule : ppi_device_model

// ===== ppi_host_test.sv
// self-checking bench for the parallel port host controller
`timescale 1ns/1ps
module ppi_host_test
    import ppi_host_pkg::*;
;
    logic        clk_sys = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, word;
    devPins_t    devPins;
    logic [7:0]  hostDataIn;
    int          failures = 0, checked = 0;
    logic [7:0]  pat [3] = '{8'h5A, 8'hA5, 8'h3C};
    ppi_host ppi_host_inst (.clk_sys(clk_sys), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .devPins(devPins), .hostDataIn(hostDataIn));
    ppi_device_model ppi_device_model_inst (.clk_sys(clk_sys),
        .devPins(devPins), .hostDataIn(hostDataIn));
    always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    task automatic conclude();
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic expectVal(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : expectVal
    // a wait that never ends is a mismatch
    task automatic bound(input int n);
        if (n > 200)
        begin
            failures++;
            $display("Error %0t: wait ran out", $time);
            conclude();
        end
    endtask : bound
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            bound(n++);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                resp = bresp;
                bready <= 1'b0;
                @(posedge clk_sys);
            end
        end while (bready);
    endtask : axiWrite
    task automatic axiRead(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            bound(n++);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                resp = rresp;
                word = rdata;
                rready <= 1'b0;
                @(posedge clk_sys);
            end
        end while (rready);
    endtask : axiRead
    // wait for the device access to finish, then clear the flags
    task automatic waitDone();
        int n;
        n = 0;
        word = 32'h0;
        while (word[ST_DONE_BIT] !== 1'b1)
        begin
            axiRead(OFF_STATUS);
            bound(n++);
        end
        axiWrite(OFF_STATUS, 32'h6);
    endtask : waitDone
    task automatic devAccess(input logic [1:0] sel, input logic [7:0] d,
                             input logic rd);
        axiWrite(OFF_COMMAND, {19'h0, rd, 2'h0, sel, d});
        waitDone();
        if (rd)
            axiRead(OFF_READDATA);
    endtask : devAccess
    task automatic testResetAndRefusal();
        axiRead(OFF_CONFIG);
        expectVal(word, 32'h9B);
        axiRead(OFF_DEVRESET);
        expectVal(word, 32'h1);
        axiWrite(OFF_COMMAND, 32'h0);
        axiRead(OFF_STATUS);
        expectVal(word, 32'h4);
        axiWrite(OFF_STATUS, 32'h6);
        axiWrite(8'h18, 32'h1);
        expectVal(32'(resp), 32'(RESP_SLVERR));
        axiRead(8'h1C);
        expectVal({word[29:0], resp}, 32'(RESP_SLVERR));
    endtask : testResetAndRefusal
    task automatic testPortsAndModes();
        axiWrite(OFF_DEVRESET, 32'h0);
        for (int s = 0; s < 3; s++)
        begin
            devAccess(2'(s), 8'h00, 1'b1);
            expectVal(word, 32'hFF);
        end
        devAccess(SEL_CONTROL, 8'h00, 1'b1);
        expectVal(word, 32'h9B);
        devAccess(SEL_CONTROL, 8'h80, 1'b0);
        axiRead(OFF_CONFIG);
        expectVal(word, 32'h80);
        for (int s = 0; s < 3; s++)
        begin
            devAccess(2'(s), 8'h00, 1'b1);
            expectVal(word, 32'h00);
            devAccess(2'(s), pat[s], 1'b0);
            devAccess(2'(s), 8'h00, 1'b1);
            expectVal(word, 32'(pat[s]));
        end
        axiWrite(OFF_BITOP, 32'hF);
        waitDone();
        axiWrite(OFF_BITOP, 32'h4);
        waitDone();
        devAccess(SEL_PORT_C, 8'h00, 1'b1);
        expectVal(word, 32'hAC);
        axiRead(OFF_CONFIG);
        expectVal(word, 32'h80);
        devAccess(SEL_CONTROL, 8'h90, 1'b0);
        devAccess(SEL_PORT_B, 8'h00, 1'b1);
        expectVal(word, 32'h00);
        devAccess(SEL_CONTROL, 8'h00, 1'b1);
        expectVal(word, 32'h90);
    endtask : testPortsAndModes
    task automatic testBusyRefusal();
        axiWrite(OFF_COMMAND, {22'h0, SEL_PORT_B, 8'h11});
        axiWrite(OFF_COMMAND, {22'h0, SEL_PORT_A, 8'h22});
        axiRead(OFF_STATUS);
        expectVal(word, 32'h5);
        waitDone();
        devAccess(SEL_PORT_B, 8'h00, 1'b1);
        expectVal(word, 32'h11);
        devAccess(SEL_PORT_A, 8'h00, 1'b1);
        expectVal(word, 32'h5A);
    endtask : testBusyRefusal
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        testResetAndRefusal();
        testPortsAndModes();
        testBusyRefusal();
        conclude();
    end
endmodule : ppi_host_test
bind ppi_host ppi_host_monitor ppi_host_monitor_inst (.clk_sys(clk_sys),
    .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .bvalid(bvalid), .devPins(devPins));
